// [hdl/ccr_readout.sv]
`timescale 1ns/1ps
module ccr_readout
  import ccr_pkg::*;
(
  input wire logic clk,
  input wire logic osc_clk,
  input wire logic reset,
  input wire logic shift_load_sel,
  input wire logic load_src_sel,
  input wire logic [31:0] check_value,
  input wire logic [31:0] signature,
  input wire logic signature_valid,
  output logic serial_out,
  output logic mismatch
);

  // ---------------------------------------------------------------
  // load phase encoding
  // ---------------------------------------------------------------
  // shift: the last edge shifted, or reset was applied
  // armed: one low edge seen, nothing loaded yet
  // load: the register was loaded on the last edge
  typedef enum logic [2:0] {
    CCR_PH_SHIFT = 3'b001,
    CCR_PH_ARMED = 3'b010,
    CCR_PH_LOAD = 3'b100
  } ccr_phase_t;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // one step toward the serial output, zeros enter at the top
  function automatic logic [31:0] ccr_shift_step(
    input logic [31:0] cur
  );
    logic [31:0] moved;
    moved = {1'b0, cur[31:1]};
    ccr_shift_step = moved;
  endfunction : ccr_shift_step

  // picks the word for a parallel load
  function automatic logic [31:0] ccr_load_word(
    input logic src,
    input logic [31:0] stored,
    input logic [31:0] computed
  );
    logic [31:0] word;
    if (src) begin
      word = computed;
    end else begin
      word = stored;
    end
    ccr_load_word = word;
  endfunction : ccr_load_word

  // true when this low edge completes the required low run
  function automatic logic ccr_load_due(
    input logic [1:0] cnt
  );
    logic [1:0] after_edge;
    after_edge = cnt + 2'h1;
    ccr_load_due = (after_edge >= CCR_LOAD_CYCLES);
  endfunction : ccr_load_due

  // true when the two words disagree
  function automatic logic ccr_words_differ(
    input logic [31:0] a,
    input logic [31:0] b
  );
    logic differ;
    differ = (a != b);
    ccr_words_differ = differ;
  endfunction : ccr_words_differ

  // ---------------------------------------------------------------
  // low run counter (user clock)
  // ---------------------------------------------------------------
  logic [1:0] low_cnt_ff;
  logic [1:0] nxt_low_cnt;

  always_comb begin
    nxt_low_cnt = low_cnt_ff;
    if (shift_load_sel) begin
      nxt_low_cnt = 2'h0;
    end else if (low_cnt_ff != CCR_LOAD_CYCLES) begin
      nxt_low_cnt = low_cnt_ff + 2'h1;
    end else begin
      nxt_low_cnt = low_cnt_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      low_cnt_ff <= 2'h0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  // ---------------------------------------------------------------
  // load phase (user clock)
  // ---------------------------------------------------------------
  ccr_phase_t phase_ff;
  ccr_phase_t nxt_phase;

  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      CCR_PH_SHIFT: begin
        if (shift_load_sel) begin
          nxt_phase = CCR_PH_SHIFT;
        end else if (ccr_load_due(low_cnt_ff)) begin
          nxt_phase = CCR_PH_LOAD;
        end else begin
          nxt_phase = CCR_PH_ARMED;
        end
      end
      CCR_PH_ARMED: begin
        if (shift_load_sel) begin
          // a single low cycle loads nothing
          nxt_phase = CCR_PH_SHIFT;
        end else if (ccr_load_due(low_cnt_ff)) begin
          nxt_phase = CCR_PH_LOAD;
        end else begin
          nxt_phase = CCR_PH_ARMED;
        end
      end
      CCR_PH_LOAD: begin
        if (shift_load_sel) begin
          nxt_phase = CCR_PH_SHIFT;
        end else begin
          // held low: reload on every further edge
          nxt_phase = CCR_PH_LOAD;
        end
      end
      default: begin
        nxt_phase = CCR_PH_SHIFT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_ff <= CCR_PH_SHIFT;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // ---------------------------------------------------------------
  // readout shift register (user clock)
  // ---------------------------------------------------------------
  logic [31:0] shreg_ff;
  logic [31:0] nxt_shreg;
  logic load_now;

  always_comb begin
    nxt_shreg = shreg_ff;
    load_now = (nxt_phase == CCR_PH_LOAD) && !shift_load_sel;
    if (shift_load_sel) begin
      // load source is not looked at here
      nxt_shreg = ccr_shift_step(shreg_ff);
    end else if (load_now) begin
      nxt_shreg = ccr_load_word(load_src_sel, check_value, signature);
    end else begin
      nxt_shreg = shreg_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shreg_ff <= CCR_RESET_VAL;
    end else begin
      shreg_ff <= nxt_shreg;
    end
  end

  // ---------------------------------------------------------------
  // serial output
  // ---------------------------------------------------------------
  // bit 0 is the next bit the reader sees
  assign serial_out = shreg_ff[0];

  // ---------------------------------------------------------------
  // mismatch flag (internal oscillator)
  // ---------------------------------------------------------------
  logic differ_now;
  logic mismatch_ff;
  logic nxt_mismatch;

  always_comb begin
    differ_now = ccr_words_differ(signature, check_value);
    nxt_mismatch = mismatch_ff;
    if (signature_valid) begin
      nxt_mismatch = differ_now;
    end else begin
      nxt_mismatch = mismatch_ff;
    end
  end

  always_ff @(posedge osc_clk) begin
    if (reset) begin
      mismatch_ff <= 1'b0;
    end else begin
      mismatch_ff <= nxt_mismatch;
    end
  end

  // launched by osc_clk: a clk domain reader must synchronise it
  assign mismatch = mismatch_ff;

endmodule : ccr_readout

// [hdl/ccr_pkg.sv]
// Functional notes
// - every load and shift of the detector cell happens on the rising edge of clk.
// - while shift_load_sel is 1 the shift register moves one bit toward the serial output per edge.
// - on a load with load_src_sel 0 the stored check value is copied into the 32-bit register.
// - on a load with load_src_sel 1 the computed signature is copied instead.
// - load_src_sel is ignored while shift_load_sel is 1.
// - the mismatch flag is timed by the internal oscillator, not by clk.
// - the mismatch flag goes high when signature_valid is 1 and the signature differs from the check value.
package ccr_pkg;
  localparam int CCR_WIDTH = 32;
  localparam logic [31:0] CCR_RESET_VAL = 32'h0000_0000;
  localparam logic [1:0] CCR_LOAD_CYCLES = 2'h2;
  localparam int CCR_OSC_MHZ = 80;
  localparam int CCR_CLK_MHZ = 40;
endpackage : ccr_pkg

// [testbench/ccr_readout_checker.sv]
`timescale 1ns/1ps
module ccr_readout_checker (
  input wire logic clk,
  input wire logic osc_clk,
  input wire logic reset,
  input wire logic shift_load_sel,
  input wire logic load_src_sel,
  input wire logic [31:0] check_value,
  input wire logic [31:0] signature,
  input wire logic signature_valid,
  input wire logic serial_out,
  input wire logic mismatch
);
  // ---------------------------------------------------------------
  // reference register built from the readout rules
  // ---------------------------------------------------------------
  logic [31:0] model_ff;
  logic [31:0] nxt_model;
  logic low_seen_ff;
  logic nxt_low_seen;

  always_comb begin
    nxt_model = model_ff;
    nxt_low_seen = 1'b0;
    if (shift_load_sel) begin
      nxt_model = {1'b0, model_ff[31:1]};
    end else begin
      nxt_low_seen = 1'b1;
      if (low_seen_ff) begin
        nxt_model = load_src_sel ? signature : check_value;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      model_ff <= 32'h0000_0000;
      low_seen_ff <= 1'b0;
    end else begin
      model_ff <= nxt_model;
      low_seen_ff <= nxt_low_seen;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_reset_clears_out: assert property (@(posedge clk) reset |=> !serial_out)
    else $error("serial out not cleared by reset");
  a_serial_matches: assert property (
    @(posedge clk) disable iff (reset) serial_out == model_ff[0])
    else $error("serial out differs from reference register");
  a_load_check_value: assert property (
    @(posedge clk) disable iff (reset)
    !shift_load_sel && !$past(shift_load_sel) && !$past(reset) && !load_src_sel
    |=> serial_out == $past(check_value[0]))
    else $error("check value not loaded");
  a_load_signature: assert property (
    @(posedge clk) disable iff (reset)
    !shift_load_sel && !$past(shift_load_sel) && !$past(reset) && load_src_sel
    |=> serial_out == $past(signature[0]))
    else $error("signature not loaded");
  a_single_low_hold: assert property (
    @(posedge clk) disable iff (reset)
    $past(shift_load_sel) && !shift_load_sel |=> $stable(serial_out))
    else $error("single low cycle changed the register");
  a_mismatch_on_diff: assert property (
    @(posedge osc_clk) disable iff (reset)
    signature_valid && (signature != check_value) |=> mismatch)
    else $error("mismatch not raised on differing words");
  a_mismatch_on_match: assert property (
    @(posedge osc_clk) disable iff (reset)
    signature_valid && (signature == check_value) |=> !mismatch)
    else $error("mismatch raised on equal words");
  a_mismatch_holds: assert property (
    @(posedge osc_clk) disable iff (reset) !signature_valid |=> $stable(mismatch))
    else $error("mismatch changed without a compare");
  a_reset_clears_flag: assert property (@(posedge osc_clk) reset |=> !mismatch)
    else $error("mismatch not cleared by reset");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  c_load_then_shift: cover property (@(posedge clk) !shift_load_sel [*2] ##1 shift_load_sel);
  c_signature_load: cover property (
    @(posedge clk) (!shift_load_sel && load_src_sel) [*2] ##1 shift_load_sel);
  c_single_low: cover property (
    @(posedge clk) shift_load_sel ##1 !shift_load_sel ##1 shift_load_sel);
  c_mismatch_rise: cover property (@(posedge osc_clk) $rose(mismatch));
endmodule : ccr_readout_checker
bind ccr_readout ccr_readout_checker ccr_readout_checker_inst (
  .clk(clk),
  .osc_clk(osc_clk),
  .reset(reset),
  .shift_load_sel(shift_load_sel),
  .load_src_sel(load_src_sel),
  .check_value(check_value),
  .signature(signature),
  .signature_valid(signature_valid),
  .serial_out(serial_out),
  .mismatch(mismatch)
);

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk = 0, osc = 0, reset = 1, sl = 1, src = 0, sv = 0, so, mm;
  logic [31:0] cv = 32'h8c3a_51e7, sg = 32'h1234_5678;
  int fails = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  always #6.25 osc = ~osc;
  ccr_readout ccr_readout_inst (.clk(clk), .osc_clk(osc), .reset(reset),
    .shift_load_sel(sl), .load_src_sel(src), .check_value(cv), .signature(sg),
    .signature_valid(sv), .serial_out(so), .mismatch(mm));
  task chk(logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %0t %h %h", $time, s, e);
    end
  endtask : chk
  task close_out;
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task read(logic s, logic [31:0] e);
    @(negedge clk) sl = 0;
    src = s;
    @(negedge clk);
    for (int i = 0; i < 32; i++) begin
      @(negedge clk) sl = 1;
      src = ~s;
      chk(so, e[i]);
    end
  endtask : read
  task test_reset_state;
    chk(so, 0);
    chk(mm, 0);
  endtask : test_reset_state
  task test_load_check;
    read(0, cv);
  endtask : test_load_check
  task test_load_signature;
    read(1, sg);
  endtask : test_load_signature
  task test_single_low;
    @(negedge clk) sl = 0;
    src = 0;
    @(negedge clk);
    @(negedge clk) sl = 1;
    chk(so, cv[0]);
    @(negedge clk) chk(so, cv[1]);
    @(negedge clk) sl = 0;
    src = 1;
    chk(so, cv[2]);
    @(negedge clk) sl = 1;
    chk(so, cv[2]);
    @(negedge clk) chk(so, cv[3]);
  endtask : test_single_low
  task test_mismatch;
    chk(mm, 0);
    @(negedge clk) sv = 1;
    repeat (2) @(negedge clk);
    chk(mm, 1);
    sg = cv;
    repeat (2) @(negedge clk);
    chk(mm, 0);
    sv = 0;
    sg = 32'h1234_5678;
    repeat (2) @(negedge clk);
    chk(mm, 0);
    sv = 1;
    repeat (2) @(negedge clk);
    chk(mm, 1);
  endtask : test_mismatch
  task test_recover;
    reset = 1;
    sv = 0;
    repeat (2) @(negedge clk);
    reset = 0;
    chk(mm, 0);
    chk(so, 0);
  endtask : test_recover
  initial begin
    repeat (2) @(negedge clk);
    reset = 0;
    test_reset_state();
    test_load_check();
    test_load_signature();
    test_single_low();
    test_mismatch();
    test_recover();
    close_out();
  end
  initial begin
    #20000;
    fails++;
    close_out();
  end
endmodule : testbench
